// ==== hw/tas_top.sv ====
// thermal alarm pin (timed input, critical-limit output) and tach routing
// assumes an 8-bit register port, per-channel temperatures in quarter degrees
// with a one-cycle update pulse per monitoring cycle, and an external pull-up
`timescale 1ns/1ps
// What this block does
// - mask bit suppresses alert for timer events
// - zero limit alerts on first assertion
// - nonzero limit alerts once time exceeds limit
// - enabled channel over limit drives pin low
// - pin held low until temp at limit
// - output assertion lasts a monitoring cycle
// - three critical limits at consecutive addresses
// - config bit 3 lets channel drive pin
// - four tach inputs, three drive outputs
// - default tach one-three follow matching drive output, tach four follows drive three
// - sync bit routes tach two-four to drive two
// - timer accumulates, clears on read, saturates
// - bit 0 first, then 22.76 ms steps
// - exceed flag sets even when masked
// - monitoring only while function enable set
module tas_top #(
	parameter int unsigned TIMER_LSB_CYCLES = tas_pkg::TIMER_LSB_CYCLES
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// temperature measurements
	input wire logic [tas_pkg::TEMP_W-1:0] temp_remote1,
	input wire logic [tas_pkg::TEMP_W-1:0] temp_local,
	input wire logic [tas_pkg::TEMP_W-1:0] temp_remote2,
	input wire logic [tas_pkg::NUM_CHAN-1:0] temp_update,
	// thermal alarm pin, open drain
	input wire logic thermal_alarm_pin_in,
	output logic thermal_alarm_pin_out,
	output logic thermal_alarm_pin_oe,
	// alert and status
	output logic thermal_alert,
	output logic alarm_time_exceeded_flag,
	// tach pins and fan drives
	input wire logic fan1_speed_input,
	input wire logic fan2_speed_input,
	input wire logic fan3_speed_input,
	input wire logic fan4_speed_input,
	input wire logic fan_drive_out_1,
	input wire logic fan_drive_out_2,
	input wire logic fan_drive_out_3,
	output logic [tas_pkg::NUM_TACH-1:0] tach_level,
	output logic [tas_pkg::NUM_TACH-1:0] tach_drive_level,
	output logic [2*tas_pkg::NUM_TACH-1:0] tach_source
);
	logic [7:0] cfg_reg [tas_pkg::NUM_CHAN];
	logic [7:0] lim_reg [tas_pkg::NUM_CHAN];
	logic [7:0] acou1_reg;
	logic [7:0] mask2_reg;
	logic [7:0] cfg3_reg;
	logic [7:0] tlimit_reg;
	logic flag_reg;
	logic flag_next;
	logic [tas_pkg::NUM_CHAN-1:0] over_reg;
	logic drive_reg;
	logic drive_next;
	logic [2:0] drive_hist_reg;
	logic pin_s1_reg;
	logic pin_s2_reg;
	logic alert_reg;
	logic [7:0] rd_mux;
	logic [tas_pkg::TEMP_W-1:0] temps [tas_pkg::NUM_CHAN];
	logic [tas_pkg::NUM_CHAN-1:0] chan_en;
	logic alarm_en;
	logic pin_low;
	logic own_drive;
	logic timer_clr;
	logic stat_clr;
	logic flag_set;
	logic wr_acou1;
	logic wr_mask2;
	logic wr_cfg3;
	logic wr_tlimit;

	tas_timer_if tif ();

	// temperature exceeds limit by a quarter degree or more
	function automatic logic over_limit(input logic [tas_pkg::TEMP_W-1:0] t,
		input logic [7:0] lim);
		over_limit = t > {lim, 2'b00};
	endfunction

	// index of a channel register within a block of three, or 3 if outside
	function automatic logic [1:0] chan_index(input logic [7:0] a, input logic [7:0] base);
		if (a >= base && a < base + 8'h03)
			chan_index = 2'(a - base);
		else
			chan_index = 2'd3;
	endfunction

	////////////////////////////////////////////////////////////////
	// decode
	assign temps[0] = temp_remote1;
	assign temps[1] = temp_local;
	assign temps[2] = temp_remote2;
	assign alarm_en = cfg3_reg[tas_pkg::CFG3_EN_BIT];
	assign wr_acou1 = reg_wr && reg_addr == tas_pkg::ADDR_ACOU1;
	assign wr_mask2 = reg_wr && reg_addr == tas_pkg::ADDR_MASK2;
	assign wr_cfg3 = reg_wr && reg_addr == tas_pkg::ADDR_CFG3;
	assign wr_tlimit = reg_wr && reg_addr == tas_pkg::ADDR_TLIMIT;
	assign timer_clr = reg_rd && reg_addr == tas_pkg::ADDR_TIMER;
	assign stat_clr = reg_rd && reg_addr == tas_pkg::ADDR_STATUS2;

	////////////////////////////////////////////////////////////////
	// per-channel config and critical limit registers
	generate
		for (genvar i = 0; i < tas_pkg::NUM_CHAN; i++) begin : g_chan
			logic wr_cfg;
			logic wr_lim;
			assign wr_cfg = reg_wr && chan_index(reg_addr, tas_pkg::ADDR_R1_CFG) == 2'(i);
			assign wr_lim = reg_wr && chan_index(reg_addr, tas_pkg::ADDR_R1_LIM) == 2'(i);
			assign chan_en[i] = cfg_reg[i][tas_pkg::CFG_OUT_EN_BIT];
			// register storage and once-per-cycle over-limit evaluation
			always_ff @(posedge sys_clk) begin
				if (sys_rst) begin
					cfg_reg[i] <= tas_pkg::RST_CFG;
					lim_reg[i] <= tas_pkg::RST_LIM;
					over_reg[i] <= 1'b0;
				end else begin
					if (wr_cfg)
						cfg_reg[i] <= reg_wdata;
					if (wr_lim)
						lim_reg[i] <= reg_wdata;
					if (temp_update[i])
						over_reg[i] <= over_limit(temps[i], lim_reg[i]);
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// global control registers
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			acou1_reg <= tas_pkg::RST_CFG;
			mask2_reg <= tas_pkg::RST_MASK2;
			cfg3_reg <= tas_pkg::RST_CFG3;
			tlimit_reg <= tas_pkg::RST_TLIMIT;
		end else begin
			if (wr_acou1)
				acou1_reg <= reg_wdata;
			if (wr_mask2)
				mask2_reg <= reg_wdata;
			if (wr_cfg3)
				cfg3_reg <= reg_wdata;
			if (wr_tlimit)
				tlimit_reg <= reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////
	// output drive: OR of enabled channels that are over their limit
	assign drive_next = alarm_en && |(over_reg & chan_en);
	assign thermal_alarm_pin_out = 1'b0;
	assign thermal_alarm_pin_oe = drive_reg;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			drive_reg <= 1'b0;
			drive_hist_reg <= 3'h0;
		end else begin
			drive_reg <= drive_next;
			drive_hist_reg <= {drive_hist_reg[1:0], drive_reg};
		end
	end

	////////////////////////////////////////////////////////////////
	// pin input sync; own drive is masked for the sync delay plus one
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pin_s1_reg <= 1'b1;
			pin_s2_reg <= 1'b1;
		end else begin
			pin_s1_reg <= thermal_alarm_pin_in;
			pin_s2_reg <= pin_s1_reg;
		end
	end

	assign pin_low = !pin_s2_reg;
	assign own_drive = drive_reg || |drive_hist_reg;
	assign tif.active = alarm_en && pin_low && !own_drive;
	assign tif.clear = timer_clr;

	tas_alarm_timer #(
		.LSB_CYCLES(TIMER_LSB_CYCLES)
	) u_timer (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.tif(tif)
	);

	////////////////////////////////////////////////////////////////
	// exceed flag (set wins over read clear) and masked alert
	assign flag_set = alarm_en && tif.value > tlimit_reg;
	assign flag_next = flag_set || (flag_reg && !stat_clr);

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			flag_reg <= 1'b0;
			alert_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
			alert_reg <= flag_reg && !mask2_reg[tas_pkg::MASK_TIMER_BIT];
		end
	end

	assign alarm_time_exceeded_flag = flag_reg;
	assign thermal_alert = alert_reg;

	////////////////////////////////////////////////////////////////
	// read mux; unmapped addresses read zero
	always_comb begin
		rd_mux = 8'h00;
		case (reg_addr)
			tas_pkg::ADDR_R1_CFG: rd_mux = cfg_reg[0];
			tas_pkg::ADDR_LOC_CFG: rd_mux = cfg_reg[1];
			tas_pkg::ADDR_R2_CFG: rd_mux = cfg_reg[2];
			tas_pkg::ADDR_ACOU1: rd_mux = acou1_reg;
			tas_pkg::ADDR_R1_LIM: rd_mux = lim_reg[0];
			tas_pkg::ADDR_LOC_LIM: rd_mux = lim_reg[1];
			tas_pkg::ADDR_R2_LIM: rd_mux = lim_reg[2];
			tas_pkg::ADDR_MASK2: rd_mux = mask2_reg;
			tas_pkg::ADDR_CFG3: rd_mux = cfg3_reg;
			tas_pkg::ADDR_TLIMIT: rd_mux = tlimit_reg;
			tas_pkg::ADDR_TIMER: rd_mux = tif.value;
			tas_pkg::ADDR_STATUS2: rd_mux = 8'(flag_reg) << tas_pkg::STAT_TIMER_BIT;
			default: rd_mux = 8'h00;
		endcase
	end

	// read data registered one cycle after the strobe
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd)
				reg_rdata <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////
	// tach routing
	tas_tach_sync u_tach (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.tach_pin({fan4_speed_input, fan3_speed_input, fan2_speed_input, fan1_speed_input}),
		.drive_level({fan_drive_out_3, fan_drive_out_2, fan_drive_out_1}),
		.sync_to_two(acou1_reg[tas_pkg::ACOU_SYNC_BIT]),
		.tach_level(tach_level),
		.tach_drive_level(tach_drive_level),
		.tach_source(tach_source)
	);

	////////////////////////////////////////////////////////////////
	// checks
	property p_mask;
		@(posedge sys_clk) disable iff (sys_rst)
		mask2_reg[5] && $past(mask2_reg[5]) |-> !thermal_alert;
	endproperty
	a_mask: assert property (p_mask) else $error("alert seen while masked");

	property p_flag_masked;
		@(posedge sys_clk) disable iff (sys_rst)
		alarm_en && tif.value > tlimit_reg |=> alarm_time_exceeded_flag;
	endproperty
	a_flag_masked: assert property (p_flag_masked) else $error("exceed flag not set");

	property p_zero_limit;
		@(posedge sys_clk) disable iff (sys_rst)
		alarm_en && tlimit_reg == 8'h00 && tif.active && !timer_clr && !wr_cfg3 && !wr_tlimit
			|=> ##1 alarm_time_exceeded_flag;
	endproperty
	a_zero_limit: assert property (p_zero_limit) else $error("no flag on first assertion");

	property p_limit_cause;
		@(posedge sys_clk) disable iff (sys_rst)
		$rose(flag_reg) |-> $past(tif.value) > $past(tlimit_reg);
	endproperty
	a_limit_cause: assert property (p_limit_cause) else $error("flag set below limit");

	property p_drive;
		@(posedge sys_clk) disable iff (sys_rst)
		alarm_en && chan_en[0] && over_reg[0] && !reg_wr |=> thermal_alarm_pin_oe;
	endproperty
	a_drive: assert property (p_drive) else $error("pin not driven when over limit");

	// oe now reflects state two edges old; an update or write one edge ago may still drop it
	property p_hold;
		@(posedge sys_clk) disable iff (sys_rst)
		thermal_alarm_pin_oe && $past(temp_update) == 3'h0 && !$past(reg_wr)
			|=> thermal_alarm_pin_oe;
	endproperty
	a_hold: assert property (p_hold) else $error("pin released between updates");

	property p_release;
		@(posedge sys_clk) disable iff (sys_rst)
		over_reg == 3'h0 |=> !thermal_alarm_pin_oe;
	endproperty
	a_release: assert property (p_release) else $error("pin held with no channel over");

	property p_own_drive;
		@(posedge sys_clk) disable iff (sys_rst)
		thermal_alarm_pin_oe |-> !tif.active;
	endproperty
	a_own_drive: assert property (p_own_drive) else $error("own drive counted");

	property p_disabled;
		@(posedge sys_clk) disable iff (sys_rst)
		!alarm_en && !wr_cfg3 |=> !thermal_alarm_pin_oe && !tif.active;
	endproperty
	a_disabled: assert property (p_disabled) else $error("alarm active while disabled");
endmodule

// ==== hw/tas_pkg.sv ====
// constants, register map and types for the thermal alarm and tach sync block
// assumes a 100 MHz sys_clk and an 8-bit register port in front of it
package tas_pkg;
	// register offsets
	localparam logic [7:0] ADDR_R1_CFG = 8'h5f;
	localparam logic [7:0] ADDR_LOC_CFG = 8'h60;
	localparam logic [7:0] ADDR_R2_CFG = 8'h61;
	localparam logic [7:0] ADDR_ACOU1 = 8'h62;
	localparam logic [7:0] ADDR_R1_LIM = 8'h6a;
	localparam logic [7:0] ADDR_LOC_LIM = 8'h6b;
	localparam logic [7:0] ADDR_R2_LIM = 8'h6c;
	localparam logic [7:0] ADDR_STATUS2 = 8'h42;
	localparam logic [7:0] ADDR_MASK2 = 8'h75;
	localparam logic [7:0] ADDR_CFG3 = 8'h78;
	localparam logic [7:0] ADDR_TIMER = 8'h79;
	localparam logic [7:0] ADDR_TLIMIT = 8'h7a;
	// field positions
	localparam int CFG_OUT_EN_BIT = 3;
	localparam int ACOU_SYNC_BIT = 4;
	localparam int MASK_TIMER_BIT = 5;
	localparam int STAT_TIMER_BIT = 5;
	localparam int CFG3_EN_BIT = 1;
	// values after reset, and timer full scale
	localparam logic [7:0] RST_CFG = 8'h00;
	localparam logic [7:0] RST_LIM = 8'h64;
	localparam logic [7:0] RST_MASK2 = 8'h00;
	localparam logic [7:0] RST_CFG3 = 8'h00;
	localparam logic [7:0] RST_TLIMIT = 8'h00;
	localparam logic [7:0] TIMER_FULL = 8'hff;
	// timing: one timer lsb step, in ns and in clock cycles
	localparam int CLK_PERIOD_NS = 10;
	localparam int TIMER_LSB_NS = 22760000;
	localparam int TIMER_LSB_CYCLES = TIMER_LSB_NS / CLK_PERIOD_NS;
	// sizes
	localparam int NUM_CHAN = 3;
	localparam int NUM_TACH = 4;
	localparam int NUM_DRIVE = 3;
	localparam int TEMP_W = 10;
	// which fan drive output a tach measurement follows
	typedef enum logic [1:0] {
		TAS_DRV1 = 2'b00,
		TAS_DRV2 = 2'b01,
		TAS_DRV3 = 2'b10
	} tas_drive_sel_t;
endpackage

// ==== hw/tas_timer_if.sv ====
// carrier between the top and the assertion timer
// assumes both ends on sys_clk
`timescale 1ns/1ps
interface tas_timer_if;
	logic active;
	logic clear;
	logic [7:0] value;
	modport ctrl (output active, output clear, input value);
	modport timer (input active, input clear, output value);
endinterface

// ==== hw/tas_alarm_timer.sv ====
// cumulative low-time timer for the thermal alarm input
// assumes active is already synchronised and qualified; clear is a read pulse
`timescale 1ns/1ps
module tas_alarm_timer #(
	parameter int unsigned LSB_CYCLES = tas_pkg::TIMER_LSB_CYCLES
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// timer carrier
	tas_timer_if.timer tif
);
	localparam int SUB_W = $clog2(LSB_CYCLES + 1);
	localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(LSB_CYCLES - 1);

	logic [SUB_W-1:0] sub_reg;
	logic [7:0] units_reg;
	logic seen_reg;
	logic full;
	logic wrap;

	////////////////////////////////////////////////////////////////
	// decode
	assign full = (units_reg == tas_pkg::TIMER_FULL);
	assign wrap = (sub_reg == SUB_LAST);
	// bit 0 shows the first assertion until the count passes one step
	assign tif.value = (units_reg == 8'h00 && seen_reg) ? 8'h01 : units_reg;

	////////////////////////////////////////////////////////////////
	// accumulate, clear on read, stop at full scale
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sub_reg <= '0;
			units_reg <= 8'h00;
			seen_reg <= 1'b0;
		end else if (tif.clear) begin
			sub_reg <= '0;
			units_reg <= 8'h00;
			seen_reg <= tif.active; // read during assertion keeps bit 0
		end else if (tif.active && !full) begin
			seen_reg <= 1'b1;
			if (wrap) begin
				sub_reg <= '0;
				units_reg <= units_reg + 8'h01;
			end else begin
				sub_reg <= sub_reg + SUB_W'(1);
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// checks
	property p_saturate;
		@(posedge sys_clk) disable iff (sys_rst)
		full && !tif.clear |=> full;
	endproperty
	a_saturate: assert property (p_saturate) else $error("timer left full scale");

	property p_first_assert;
		@(posedge sys_clk) disable iff (sys_rst)
		tif.active && !tif.clear |=> tif.value != 8'h00;
	endproperty
	a_first_assert: assert property (p_first_assert) else $error("bit 0 not set");

	property p_clear;
		@(posedge sys_clk) disable iff (sys_rst)
		tif.clear && !tif.active |=> tif.value == 8'h00;
	endproperty
	a_clear: assert property (p_clear) else $error("timer not cleared on read");
endmodule

// ==== hw/tas_tach_sync.sv ====
// routes each tach measurement to the fan drive output it follows
// assumes tach pins are asynchronous and drive levels come from sys_clk logic
`timescale 1ns/1ps
module tas_tach_sync (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// pins and drives
	input wire logic [tas_pkg::NUM_TACH-1:0] tach_pin,
	input wire logic [tas_pkg::NUM_DRIVE-1:0] drive_level,
	// control
	input wire logic sync_to_two,
	// results
	output logic [tas_pkg::NUM_TACH-1:0] tach_level,
	output logic [tas_pkg::NUM_TACH-1:0] tach_drive_level,
	output logic [2*tas_pkg::NUM_TACH-1:0] tach_source
);
	logic [tas_pkg::NUM_TACH-1:0] s1_reg;
	logic [tas_pkg::NUM_TACH-1:0] s2_reg;
	logic [2*tas_pkg::NUM_TACH-1:0] src_next;
	logic [tas_pkg::NUM_TACH-1:0] lvl_next;

	// drive output that a tach input follows
	function automatic tas_pkg::tas_drive_sel_t sel_for(input int idx, input logic two);
		if (idx == 0)
			sel_for = tas_pkg::TAS_DRV1;
		else if (two)
			sel_for = tas_pkg::TAS_DRV2;
		else if (idx == 1)
			sel_for = tas_pkg::TAS_DRV2;
		else
			sel_for = tas_pkg::TAS_DRV3;
	endfunction

	////////////////////////////////////////////////////////////////
	// selection: four tach inputs over three drive outputs
	generate
		for (genvar i = 0; i < tas_pkg::NUM_TACH; i++) begin : g_sel
			assign src_next[2*i +: 2] = sel_for(i, sync_to_two);
			assign lvl_next[i] = drive_level[src_next[2*i +: 2]];
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// two-stage sync of tach pins, registered results
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s1_reg <= '0;
			s2_reg <= '0;
			tach_level <= '0;
			tach_drive_level <= '0;
			tach_source <= '0;
		end else begin
			s1_reg <= tach_pin;
			s2_reg <= s1_reg;
			tach_level <= s2_reg;
			tach_drive_level <= lvl_next;
			tach_source <= src_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// checks
	property p_sync_two;
		@(posedge sys_clk) disable iff (sys_rst)
		sync_to_two |=> tach_source == 8'h54;
	endproperty
	a_sync_two: assert property (p_sync_two) else $error("tach not routed to drive two");

	property p_sync_default;
		@(posedge sys_clk) disable iff (sys_rst)
		!sync_to_two |=> tach_source == 8'ha4;
	endproperty
	a_sync_default: assert property (p_sync_default) else $error("default tach routing wrong");
endmodule

// ==== test/tas_pin_model.sv ====
// far side of the thermal alarm pin: an outside low driver and the pull-up
// assumes the device reports its own pull-low through pin_oe
`timescale 1ns/1ps
module tas_pin_model (
	// from the bench
	input wire logic ext_low,
	// from the device
	input wire logic pin_out,
	input wire logic pin_oe,
	// resolved wire
	output logic pin_level
);
	// open drain wire: any party pulls low, otherwise the pull-up wins
	assign pin_level = ((pin_oe && !pin_out) || ext_low) ? 1'b0 : 1'b1;
endmodule

// ==== test/tas_top_tb.sv ====
// self-checking bench for the thermal alarm pin and tach routing block
// assumes a short timer step of 8 cycles; inputs change on the falling edge
`timescale 1ns/1ps
module tas_top_tb;
	////////////////////////////////////////////////////////////////////////////
	// stimulus and observed signals
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [9:0] temp [3] = '{default: 10'h000};
	logic [2:0] temp_update = 3'h0;
	logic ext_low = 1'b0;
	logic [3:0] tach = 4'h0;
	logic [2:0] drv = 3'h0;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	logic pin_level;
	logic pin_out;
	logic pin_oe;
	logic thermal_alert;
	logic flag;
	logic [3:0] tach_level;
	logic [3:0] tach_drive_level;
	logic [7:0] tach_source;
	int error_cnt = 0;
	int comparisons = 0;
	logic [7:0] exp_q [$];
	logic [7:0] wdat [10];
	logic [7:0] lim;
	localparam logic [7:0] RW_ADDR [10] = '{8'h5f, 8'h60, 8'h61, 8'h62, 8'h6a, 8'h6b, 8'h6c,
		8'h75, 8'h78, 8'h7a};
	localparam logic [7:0] RW_RST [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h64, 8'h64, 8'h64,
		8'h00, 8'h00, 8'h00};

	// free-running 100 MHz clock
	always #5 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////////////////
	// device and pin
	tas_top #(.TIMER_LSB_CYCLES(8)) tas_top_inst (
		.sys_clk(sys_clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.temp_remote1(temp[0]), .temp_local(temp[1]), .temp_remote2(temp[2]),
		.temp_update(temp_update),
		.thermal_alarm_pin_in(pin_level), .thermal_alarm_pin_out(pin_out),
		.thermal_alarm_pin_oe(pin_oe),
		.thermal_alert(thermal_alert), .alarm_time_exceeded_flag(flag),
		.fan1_speed_input(tach[0]), .fan2_speed_input(tach[1]),
		.fan3_speed_input(tach[2]), .fan4_speed_input(tach[3]),
		.fan_drive_out_1(drv[0]), .fan_drive_out_2(drv[1]), .fan_drive_out_3(drv[2]),
		.tach_level(tach_level), .tach_drive_level(tach_drive_level),
		.tach_source(tach_source)
	);
	tas_pin_model tas_pin_model_inst (
		.ext_low(ext_low), .pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level)
	);

	////////////////////////////////////////////////////////////////////////////
	// shared tasks
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("mismatches %0d of %0d compares", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// one write strobe, then a quiet edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wr = 1'b0;
	endtask

	// one read strobe; the expected byte waits in the queue
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(negedge sys_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge sys_clk);
		reg_rd = 1'b0;
	endtask

	// new measurement on one channel, then time for the pin to follow
	task automatic temp_set(input int ch, input logic [9:0] v);
		@(negedge sys_clk);
		temp[ch] = v;
		temp_update[ch] = 1'b1;
		@(negedge sys_clk);
		temp_update = 3'h0;
		idle(3);
	endtask

	// outside party holds the pin low for n cycles, then lets go
	task automatic pin_low(input int n);
		@(negedge sys_clk);
		ext_low = 1'b1;
		idle(n);
		ext_low = 1'b0;
		idle(6);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// read-data watcher: oldest note against each answer
	always @(negedge sys_clk) begin
		if (reg_rvalid === 1'b1) begin
			if (exp_q.size() == 0) begin
				error_cnt++;
				$display("BAD t=%0t unexpected read data %h", $time, reg_rdata);
			end else begin
				check(reg_rdata, exp_q.pop_front());
			end
		end
	end

	// watchdog sized well beyond the main sequence
	initial begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		wrap_up();
	end

	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		void'($urandom(87357));
		repeat (20) @(posedge sys_clk);
		@(negedge sys_clk);
		sys_rst = 1'b0;
		// reset values, random write and readback, read-only and unmapped places
		for (int i = 0; i < 10; i++) rd(RW_ADDR[i], RW_RST[i]);
		rd(tas_pkg::ADDR_TIMER, 8'h00);
		rd(tas_pkg::ADDR_STATUS2, 8'h00);
		rd(8'h10, 8'h00);
		for (int i = 0; i < 10; i++) begin
			wdat[i] = 8'($urandom);
			wr(RW_ADDR[i], wdat[i]);
		end
		wr(tas_pkg::ADDR_TIMER, 8'h55);
		for (int i = 0; i < 10; i++) rd(RW_ADDR[i], wdat[i]);
		rd(tas_pkg::ADDR_TIMER, 8'h00);
		for (int i = 0; i < 10; i++) wr(RW_ADDR[i], RW_RST[i]);
		// tach routing, default and with the sync bit
		for (int k = 0; k < 2; k++) begin
			wr(tas_pkg::ADDR_ACOU1, (k == 1) ? 8'h10 : 8'h00);
			tach = 4'($urandom);
			drv = 3'($urandom);
			idle(5);
			check({4'h0, tach_level}, {4'h0, tach});
			check({4'h0, tach_drive_level}, (k == 1) ? {4'h0, drv[1], drv[1], drv[1], drv[0]}
				: {4'h0, drv[2], drv[2], drv[1], drv[0]});
			check(tach_source, (k == 1) ? 8'h54 : 8'ha4);
		end
		// zero time limit: first assertion raises flag and alert
		wr(tas_pkg::ADDR_CFG3, 8'h02);
		pin_low(5);
		check({7'h0, flag}, 8'h01);
		check({7'h0, thermal_alert}, 8'h01);
		rd(tas_pkg::ADDR_TIMER, 8'h01);
		rd(tas_pkg::ADDR_STATUS2, 8'h20);
		rd(tas_pkg::ADDR_STATUS2, 8'h00);
		idle(2);
		check({7'h0, thermal_alert}, 8'h00);
		// limit of two steps, exceeded over three separate assertions
		wr(tas_pkg::ADDR_TLIMIT, 8'h02);
		pin_low(10);
		pin_low(10);
		check({7'h0, flag}, 8'h00);
		wr(tas_pkg::ADDR_MASK2, 8'h20);
		pin_low(10);
		check({7'h0, flag}, 8'h01);
		check({7'h0, thermal_alert}, 8'h00);
		wr(tas_pkg::ADDR_MASK2, 8'h00);
		idle(2);
		check({7'h0, thermal_alert}, 8'h01);
		rd(tas_pkg::ADDR_TIMER, 8'h03);
		rd(tas_pkg::ADDR_STATUS2, 8'h20);
		// saturation, then clear on read
		pin_low(2200);
		rd(tas_pkg::ADDR_TIMER, 8'hff);
		rd(tas_pkg::ADDR_TIMER, 8'h00);
		rd(tas_pkg::ADDR_STATUS2, 8'h20);
		// monitoring off: assertions are not timed
		wr(tas_pkg::ADDR_CFG3, 8'h00);
		pin_low(30);
		rd(tas_pkg::ADDR_TIMER, 8'h00);
		// output side, channel by channel
		wr(tas_pkg::ADDR_CFG3, 8'h02);
		for (int c = 0; c < 3; c++) begin
			lim = 8'(10 + $urandom_range(190));
			wr(tas_pkg::ADDR_R1_LIM + 8'(c), lim);
			temp_set(c, {lim, 2'b01});
			check({7'h0, pin_oe}, 8'h00);
			wr(tas_pkg::ADDR_R1_CFG + 8'(c), 8'h08);
			temp_set(c, {lim, 2'b00});
			check({7'h0, pin_oe}, 8'h00);
			temp_set(c, {lim, 2'b01});
			check({7'h0, pin_oe}, 8'h01);
			temp_set(c, 10'h3ff);
			check({7'h0, pin_oe}, 8'h01);
			temp_set(c, {lim, 2'b00});
			check({7'h0, pin_oe}, 8'h00);
		end
		// two channels over; one drops, the other still holds the pin
		temp_set(0, 10'h3ff);
		temp_set(2, 10'h3ff);
		temp_set(0, 10'h000);
		check({7'h0, pin_oe}, 8'h01);
		temp[2] = 10'h000;
		idle(20);
		check({7'h0, pin_oe}, 8'h01);
		check({6'h0, pin_out, pin_level}, 8'h00);
		rd(tas_pkg::ADDR_TIMER, 8'h00);
		temp_set(2, 10'h000);
		check({7'h0, pin_oe}, 8'h00);
		idle(6);
		rd(tas_pkg::ADDR_TIMER, 8'h00);
		idle(4);
		check(8'(exp_q.size()), 8'h00);
		wrap_up();
	end
endmodule
